// file: common/freq_prot_defs.svh
// Purpose: constants for the frequency protection stages
// Assumes: frequency words in 10 mHz steps, 40 MHz system clock
// Notes:   offsets are byte addresses on the plain register port
`ifndef FREQ_PROT_DEFS_SVH
`define FREQ_PROT_DEFS_SVH
`define CLK_PERIOD_NS   25
`define PROG_CYCLE_NS   1000000
`define MEAS_UPDATE_MS  5
`define HYST_MHZ        20
`define FREQ_LSB_MHZ    10
`define A_CTRL          10'h000
`define A_FORCE         10'h004
`define A_STATE         10'h008
`define A_IRQ_STAT      10'h00c
`define A_IRQ_MASK      10'h010
`define A_CNT_START     10'h014
`define A_CNT_TRIP      10'h018
`define A_CNT_BLK       10'h01c
`define A_CNT_CLR       10'h020
`define A_STAMP         10'h024
`define A_FREQ          10'h028
`define TAB_BIT         9
`define CTRL_ALLOW_BIT  8
`define CTRL_FORCE_BIT  9
`define CTRL_TRACK_BIT  10
`define EN_RST          2'h1
`define OVER_PICK_RST   16'h13ec
`define UNDER_PICK_RST  16'h1324
`define DELAY_RST       21'h000064
`endif

// file: common/freq_prot_pkg.sv
// Purpose: types shared by the frequency protection stages
// Assumes: codes as seen by software
// Notes:   constants live in freq_prot_defs.svh
package freq_prot_pkg;
    typedef enum logic [2:0] {
        MODE_ON       = 3'b001,
        MODE_BLOCKED  = 3'b010,
        MODE_TEST     = 3'b011,
        MODE_TEST_BLK = 3'b100,
        MODE_OFF      = 3'b101
    } node_mode_t;
    typedef enum logic [1:0] {
        FORCE_NORMAL  = 2'b00,
        FORCE_START   = 2'b01,
        FORCE_TRIP    = 2'b10,
        FORCE_BLOCKED = 2'b11
    } force_t;
    typedef enum logic [1:0] {
        EN_NO  = 2'b01,
        EN_YES = 2'b10
    } stage_en_t;
endpackage

// file: src/freq_prot.sv
// Purpose: four over- and four underfrequency stages with events
// Assumes: measurement and blocking come from logic on i_sys_clk
// Notes:   all stage logic advances once per 1 ms program cycle
// Functional notes
// - four overfrequency and four underfrequency stages, each own setting
// - per-stage enable, code 1 disabled, 2 enabled, disabled default
// - eight setting groups picked by one shared group select
// - each stage runs instant or time-delayed
// - order: input, compare, block check, delay, outputs
// - compare tracked measured frequency with pick-up in 10 mHz steps
// - frequency from first or second transformer, updated every 5 ms
// - separate start, trip and blocked outputs per stage
// - time-stamped on and off events for all three outputs
// - instant mode gives start and trip events with one stamp
// - event stamps count whole milliseconds
// - cumulative start, trip, blocked counters, clearable
// - general settings do not follow the setting group
// - node mode 1 On to 5 Off, writable only when allowed
// - forced status 0 to 3, only with stage forcing enabled
// - 20 mHz release hysteresis around each pick-up value
// - block at pick-up gives blocked instead of start, stops stage
// - delayed operation is definite time only
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "freq_prot_defs.svh"
module freq_prot #(
    parameter int STG       = 4,
    parameter int MS_CYCLES = `PROG_CYCLE_NS / `CLK_PERIOD_NS
) (
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_rst,
    input  wire logic [9:0]              i_addr,
    input  wire logic [31:0]             i_wdata,
    input  wire logic                    i_wr,
    input  wire logic                    i_rd,
    output logic [31:0]                  o_rdata,
    input  wire logic [15:0]             i_freq_vt1,
    input  wire logic [15:0]             i_freq_vt2,
    input  wire logic [2:0]              i_group_sel,
    input  wire logic                    i_block,
    output logic [2*STG-1:0]             o_start,
    output logic [2*STG-1:0]             o_trip,
    output logic [2*STG-1:0]             o_blocked,
    output logic                         o_evt_valid,
    output logic [6*STG-1:0]             o_evt_on,
    output logic [6*STG-1:0]             o_evt_off,
    output logic [31:0]                  o_evt_stamp,
    output freq_prot_pkg::node_mode_t    o_node_mode,
    output logic                         o_irq
);
    import freq_prot_pkg::*;

    localparam int N = 2 * STG;
    localparam logic [16:0] HYST = 17'(`HYST_MHZ / `FREQ_LSB_MHZ);

    // stage index and packed addresses leave room for four per direction
    generate
        if (STG < 1 || STG > 4 || MS_CYCLES < 2) begin : g_bad
            $error("freq_prot: STG must be 1..4, MS_CYCLES at least 2");
        end
    endgenerate

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    logic [31:0]  div_ff;
    logic [31:0]  stamp_ff;
    logic [2:0]   meas_ff;
    logic [15:0]  freq_ff;
    node_mode_t   mode_ff;
    logic         allow_ff;
    logic         force_en_ff;
    logic         track_ff;
    logic [2*N-1:0] force_ff;
    logic [2:0]   mask_ff;
    logic [2:0]   irq_stat_ff;
    logic [31:0]  cnt_ff [3];
    logic [17:0]  pick_mem [64];
    logic [20:0]  dly_mem [64];
    logic [N-1:0] pick_ff;
    logic [N-1:0] blk_ff;
    logic [N-1:0] nxt_pick;
    logic [N-1:0] nxt_blkst;
    logic [N-1:0] nxt_start;
    logic [N-1:0] nxt_trip;
    logic [N-1:0] nxt_blocked;

    // program cycle tick and measurement update enable
    wire tick     = (div_ff == 32'(MS_CYCLES - 1));
    wire meas_upd = tick && (meas_ff == 3'(`MEAS_UPDATE_MS - 1));

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            div_ff   <= 32'h0;
            stamp_ff <= 32'h0;
            meas_ff  <= 3'h0;
        end else begin
            div_ff <= tick ? 32'h0 : div_ff + 32'h1;
            if (tick) begin
                stamp_ff <= stamp_ff + 32'h1;
                meas_ff  <= meas_upd ? 3'h0 : meas_ff + 3'h1;
            end
        end
    end

    // sample the tracking reference only at the 5 ms update
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            freq_ff <= 16'h0;
        end else if (meas_upd) begin
            freq_ff <= track_ff ? i_freq_vt2 : i_freq_vt1;
        end
    end

    // register decode
    wire       wr_ctrl  = i_wr && (i_addr == `A_CTRL);
    wire       wr_force = i_wr && (i_addr == `A_FORCE);
    wire       wr_stat  = i_wr && (i_addr == `A_IRQ_STAT);
    wire       wr_mask  = i_wr && (i_addr == `A_IRQ_MASK);
    wire       wr_clr   = i_wr && (i_addr == `A_CNT_CLR);
    wire       wr_tab   = i_wr && i_addr[`TAB_BIT];
    wire [5:0] tab_idx  = i_addr[8:3];
    wire [2:0] wmode    = i_wdata[2:0];
    wire       mode_ok  = (wmode >= 3'(MODE_ON)) && (wmode <= 3'(MODE_OFF));

    // general settings sit outside the group table on purpose
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            mode_ff     <= MODE_ON;
            allow_ff    <= 1'b0;
            force_en_ff <= 1'b0;
            track_ff    <= 1'b0;
        end else if (wr_ctrl) begin
            if (allow_ff && mode_ok) begin
                mode_ff <= node_mode_t'(wmode);
            end
            allow_ff    <= i_wdata[`CTRL_ALLOW_BIT];
            force_en_ff <= i_wdata[`CTRL_FORCE_BIT];
            track_ff    <= i_wdata[`CTRL_TRACK_BIT];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            force_ff <= '0;
            mask_ff  <= 3'h0;
        end else begin
            if (wr_force) force_ff <= i_wdata[2*N-1:0];
            if (wr_mask)  mask_ff  <= i_wdata[2:0];
        end
    end

    // group table: reset loads disabled stages with default settings
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            for (int k = 0; k < 64; k++) begin
                pick_mem[k] <= {`EN_RST, ((k % 8) < STG) ?
                               `OVER_PICK_RST : `UNDER_PICK_RST};
                dly_mem[k]  <= `DELAY_RST;
            end
        end else if (wr_tab) begin
            if (i_addr[2]) begin
                dly_mem[tab_idx] <= i_wdata[20:0];
            end else begin
                pick_mem[tab_idx] <= i_wdata[17:0];
            end
        end
    end

    // node mode: blocked modes act as a permanent blocking input
    wire run_ok = (mode_ff != MODE_OFF);
    wire blk_in = i_block || (mode_ff == MODE_BLOCKED) ||
                  (mode_ff == MODE_TEST_BLK);

    // per-stage compare, block check, definite delay and forcing
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_stage
            logic [20:0] tmr_ff;
            wire [5:0]  sidx  = {i_group_sel, 3'(gi)};
            wire [17:0] cw    = pick_mem[sidx];
            wire [16:0] set17 = {1'b0, cw[15:0]};
            wire [16:0] f17   = {1'b0, freq_ff};
            wire        en    = (cw[17:16] == 2'(EN_YES));
            wire        over  = (gi < STG);
            // release only past the hysteresis band, avoids chatter
            wire hold  = over ? (f17 + HYST > set17)
                              : (f17 < set17 + HYST);
            wire fresh = over ? (f17 > set17) : (f17 < set17);
            wire pk_n  = run_ok && en && (pick_ff[gi] ? hold : fresh);
            // once blocked, the pick-up stays blocked until it drops
            wire bl_n  = pk_n && (blk_in ||
                         (pick_ff[gi] && blk_ff[gi]));
            wire st_n  = pk_n && !bl_n;
            // delay 0 is instant: trip in the same cycle as start
            wire tr_n  = st_n && (tmr_ff >= dly_mem[sidx]);
            wire [1:0] fc  = force_ff[2*gi +: 2];
            wire       fon = force_en_ff && (fc != 2'(FORCE_NORMAL));

            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    tmr_ff <= 21'h0;
                end else if (tick) begin
                    if (!st_n) begin
                        tmr_ff <= 21'h0;
                    end else if (tmr_ff != 21'h1fffff) begin
                        tmr_ff <= tmr_ff + 21'h1;
                    end
                end
            end

            assign nxt_pick[gi]    = pk_n;
            assign nxt_blkst[gi]   = bl_n;
            assign nxt_start[gi]   = fon ? (fc == 2'(FORCE_START) ||
                                     fc == 2'(FORCE_TRIP)) : st_n;
            assign nxt_trip[gi]    = fon ? (fc == 2'(FORCE_TRIP)) : tr_n;
            assign nxt_blocked[gi] = fon ? (fc == 2'(FORCE_BLOCKED)) : bl_n;
        end
    endgenerate

    // event vectors: one bit per stage and signal, on and off
    wire [3*N-1:0] cur_out = {o_blocked, o_trip, o_start};
    wire [3*N-1:0] nxt_out = {nxt_blocked, nxt_trip, nxt_start};
    wire [3*N-1:0] rise    = nxt_out & ~cur_out;
    wire [3*N-1:0] fall    = cur_out & ~nxt_out;

    // stage state and outputs advance only on the program cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pick_ff   <= '0;
            blk_ff    <= '0;
            o_start   <= '0;
            o_trip    <= '0;
            o_blocked <= '0;
        end else if (tick) begin
            pick_ff   <= nxt_pick;
            blk_ff    <= nxt_blkst;
            o_start   <= nxt_start;
            o_trip    <= nxt_trip;
            o_blocked <= nxt_blocked;
        end
    end

    // all changes of one cycle share a single stamp
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_evt_valid <= 1'b0;
            o_evt_on    <= '0;
            o_evt_off   <= '0;
            o_evt_stamp <= 32'h0;
        end else begin
            o_evt_valid <= tick && (rise != '0 || fall != '0);
            o_evt_on    <= tick ? rise : '0;
            o_evt_off   <= tick ? fall : '0;
            if (tick) o_evt_stamp <= stamp_ff;
        end
    end

    // rising edges per kind feed the counters and interrupt status
    function automatic logic [3:0] ones(input logic [N-1:0] v);
        logic [3:0] c;
        c = 4'h0;
        for (int k = 0; k < N; k++) c = c + 4'(v[k]);
        return c;
    endfunction

    wire [3:0] inc [3];
    wire [2:0] ev_kind;
    genvar gk;
    generate
        for (gk = 0; gk < 3; gk++) begin : g_kind
            assign inc[gk]     = tick ? ones(rise[gk*N +: N]) : 4'h0;
            assign ev_kind[gk] = (inc[gk] != 4'h0);
        end
    endgenerate

    // a clear in an event cycle keeps that cycle's count
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            for (int k = 0; k < 3; k++) cnt_ff[k] <= 32'h0;
        end else begin
            for (int k = 0; k < 3; k++) begin
                cnt_ff[k] <= (wr_clr && i_wdata[k]) ? 32'(inc[k])
                                                    : cnt_ff[k] + 32'(inc[k]);
            end
        end
    end

    // sticky status, write one to clear, new events win
    wire [2:0] w1c          = wr_stat ? i_wdata[2:0] : 3'h0;
    wire [2:0] nxt_irq_stat = (irq_stat_ff & ~w1c) | ev_kind;
    // mask written this cycle counts too, so irq never lags the mask
    wire [2:0] nxt_mask     = wr_mask ? i_wdata[2:0] : mask_ff;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            irq_stat_ff <= 3'h0;
            o_irq       <= 1'b0;
            o_node_mode <= MODE_ON;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            o_irq       <= |(nxt_irq_stat & nxt_mask);
            o_node_mode <= mode_ff;
        end
    end

    // read mux; unmapped addresses read zero
    wire [31:0] rd_ctrl  = {21'h0, track_ff, force_en_ff, allow_ff,
                            5'h0, mode_ff};
    wire [31:0] rd_state = {8'h0, 8'(o_blocked), 8'(o_trip), 8'(o_start)};
    wire [31:0] rd_tab   = i_addr[2] ? {11'h0, dly_mem[tab_idx]}
                                     : {14'h0, pick_mem[tab_idx]};
    wire [31:0] rd_mux =
        i_addr[`TAB_BIT]          ? rd_tab :
        (i_addr == `A_CTRL)      ? rd_ctrl :
        (i_addr == `A_FORCE)     ? 32'(force_ff) :
        (i_addr == `A_STATE)     ? rd_state :
        (i_addr == `A_IRQ_STAT)  ? {29'h0, irq_stat_ff} :
        (i_addr == `A_IRQ_MASK)  ? {29'h0, mask_ff} :
        (i_addr == `A_CNT_START) ? cnt_ff[0] :
        (i_addr == `A_CNT_TRIP)  ? cnt_ff[1] :
        (i_addr == `A_CNT_BLK)   ? cnt_ff[2] :
        (i_addr == `A_STAMP)     ? stamp_ff :
        (i_addr == `A_FREQ)      ? {16'h0, freq_ff} : 32'h0;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rdata <= 32'h0;
        end else begin
            o_rdata <= i_rd ? rd_mux : 32'h0;
        end
    end

    // checks
    property p_stamp;
        o_evt_valid |-> o_evt_stamp == $past(stamp_ff);
    endproperty
    a_stamp: assert property (p_stamp)
        else $error("event stamp not the cycle's ms count");

    property p_trip_with_start;
        (o_trip & ~o_start) == '0;
    endproperty
    a_trip_with_start: assert property (p_trip_with_start)
        else $error("trip without start");

    property p_blk_excl;
        !force_en_ff |-> (o_start & o_blocked) == '0;
    endproperty
    a_blk_excl: assert property (p_blk_excl)
        else $error("start and blocked together");

    property p_tick_only;
        !$past(tick) |-> $stable(o_start) && $stable(o_trip);
    endproperty
    a_tick_only: assert property (p_tick_only)
        else $error("outputs moved off the program cycle");

    property p_mode_off;
        (tick && mode_ff == MODE_OFF && !force_en_ff)
            |=> o_start == '0 && o_trip == '0 && o_blocked == '0;
    endproperty
    a_mode_off: assert property (p_mode_off)
        else $error("outputs active in off mode");

    property p_cnt_clr;
        (wr_clr && i_wdata[0] && !tick) |=> cnt_ff[0] == 32'h0;
    endproperty
    a_cnt_clr: assert property (p_cnt_clr)
        else $error("start counter not cleared");

    property p_evt_match;
        o_evt_valid |-> (o_evt_on & o_evt_off) == '0 &&
            (o_evt_on & ~{o_blocked, o_trip, o_start}) == '0;
    endproperty
    a_evt_match: assert property (p_evt_match)
        else $error("event bits disagree with outputs");

    property p_meas;
        !meas_upd |=> $stable(freq_ff);
    endproperty
    a_meas: assert property (p_meas)
        else $error("frequency moved between updates");

    property p_static;
        !wr_ctrl |=> $stable(mode_ff) && $stable(track_ff);
    endproperty
    a_static: assert property (p_static)
        else $error("general setting changed without a write");

    property p_irq;
        ##1 o_irq == |(irq_stat_ff & mask_ff);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt level wrong");

    c_instant: cover property (o_evt_valid && o_evt_on[0] && o_evt_on[N]);
    c_blocked: cover property (o_evt_valid && o_evt_on[2*N]);
    c_delayed: cover property (o_start[0] ##1 (!o_trip[0])[*3]);
    c_irq:     cover property (o_irq ##1 wr_stat);
endmodule

// file: sim/freq_meas_model.sv
// Purpose: far side model, frequency measurement and event buffer
// Assumes: one clock, the bench commands the frequency to present
// Notes:   measurement refresh is slow on purpose, like the real path
`timescale 1ns/1ps
module freq_meas_model #(
    parameter int MS_CYCLES = 10
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic [15:0] i_set_vt1,
    input  wire logic [15:0] i_set_vt2,
    output logic      [15:0] o_freq_vt1,
    output logic      [15:0] o_freq_vt2,
    input  wire logic        i_evt_valid,
    input  wire logic [23:0] i_evt_on,
    input  wire logic [23:0] i_evt_off,
    input  wire logic [31:0] i_evt_stamp
);
    int          upd_cnt;
    logic [31:0] on_stamp [24];
    logic [31:0] off_stamp [24];

    // new measurement only every 5 ms, so the block sees stale values
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || upd_cnt == 5 * MS_CYCLES - 1) begin
            upd_cnt    <= 0;
            o_freq_vt1 <= i_set_vt1;
            o_freq_vt2 <= i_set_vt2;
        end else begin
            upd_cnt <= upd_cnt + 1;
        end
    end

    // event buffer keeps the ms stamp of the last on event per bit
    always_ff @(posedge i_sys_clk) begin
        if (i_evt_valid) begin
            for (int b = 0; b < 24; b++) begin
                if (i_evt_on[b]) begin
                    on_stamp[b] <= i_evt_stamp;
                end
                if (i_evt_off[b]) begin
                    off_stamp[b] <= i_evt_stamp;
                end
            end
        end
    end
endmodule

// file: sim/freq_prot_tb.sv
// Purpose: self-checking bench for the frequency protection stages
// Assumes: 1 ms program cycle shortened to 10 clocks
// Notes:   waits are bounded, stage outputs move only on ms ticks
`timescale 1ns/1ps
`include "freq_prot_defs.svh"
module freq_prot_tb;
    import freq_prot_pkg::*;
    logic        sys_clk;
    logic        rst;
    logic [9:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [15:0] set_vt1;
    logic [15:0] set_vt2;
    logic [15:0] freq_vt1;
    logic [15:0] freq_vt2;
    logic [2:0]  group_sel;
    logic        block;
    logic [7:0]  start;
    logic [7:0]  trip;
    logic [7:0]  blocked;
    logic        evt_valid;
    logic [23:0] evt_on;
    logic [23:0] evt_off;
    logic [31:0] evt_stamp;
    node_mode_t  node_mode;
    logic        irq;
    int          fail_count;
    int          samples_checked;
    logic [31:0] d;

    freq_prot #(.MS_CYCLES(10)) dut (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_freq_vt1(freq_vt1),
        .i_freq_vt2(freq_vt2), .i_group_sel(group_sel), .i_block(block),
        .o_start(start), .o_trip(trip), .o_blocked(blocked),
        .o_evt_valid(evt_valid), .o_evt_on(evt_on), .o_evt_off(evt_off),
        .o_evt_stamp(evt_stamp), .o_node_mode(node_mode), .o_irq(irq)
    );

    freq_meas_model #(.MS_CYCLES(10)) partner (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_set_vt1(set_vt1),
        .i_set_vt2(set_vt2), .o_freq_vt1(freq_vt1),
        .o_freq_vt2(freq_vt2), .i_evt_valid(evt_valid),
        .i_evt_on(evt_on), .i_evt_off(evt_off), .i_evt_stamp(evt_stamp)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [9:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe edge
    task automatic rd_reg(input logic [9:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
        rd_reg(a, d);
        chk("register", d, exp);
    endtask

    function automatic logic [9:0] tab(input int g, s, hi);
        return 10'h200 | 10'(g * 64 + s * 8 + hi * 4);
    endfunction

    function automatic logic [7:0] outs(input int k);
        return (k == 0) ? start : (k == 1) ? trip : blocked;
    endfunction

    // kind 0 start, 1 trip, 2 blocked
    task automatic wait_out(input int k, input int b, input logic v);
        int n;
        logic [7:0] o;
        n = 0;
        o = outs(k);
        while (o[b] !== v && n < 400) begin
            @(posedge sys_clk);
            #1 n++;
            o = outs(k);
        end
        chk("stage output", {31'h0, o[b]}, {31'h0, v});
        // event buffer logs one edge after the outputs move
        @(posedge sys_clk);
        #1;
    endtask

    task automatic idle_ms(input int ms);
        repeat (ms * 10) @(posedge sys_clk);
        #1;
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        give_verdict();
    end

    initial begin
        fail_count = 0;
        samples_checked = 0;
        rst = 1'b1; addr = 10'h0; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
        set_vt1 = 16'd5000; set_vt2 = 16'd5000; group_sel = 3'h0;
        block = 1'b0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        // table defaults and an unmapped hole
        rd_chk(tab(0, 0, 0), 32'h000113ec);
        rd_chk(tab(7, 4, 0), 32'h00011324);
        rd_chk(tab(0, 7, 1), 32'h00000064);
        rd_chk(10'h100, 32'h0);
        chk("node mode", 32'(node_mode), 32'(MODE_ON));
        // mode field refused until the allow bit is already set
        wr_reg(`A_CTRL, 32'h005);
        wr_reg(`A_CTRL, 32'h105);
        idle_ms(1);
        chk("node mode", 32'(node_mode), 32'(MODE_ON));
        wr_reg(`A_CTRL, 32'h105);
        wr_reg(`A_CTRL, 32'h106);
        idle_ms(1);
        chk("node mode", 32'(node_mode), 32'(MODE_OFF));
        wr_reg(`A_CTRL, 32'h101);
        idle_ms(15);
        // one over stage delayed 3 ms, one under stage instant
        wr_reg(`A_CNT_CLR, 32'h7);
        rd_chk(`A_CNT_START, 32'h0);
        wr_reg(tab(0, 0, 0), {14'h0, EN_YES, 16'd5100});
        wr_reg(tab(0, 0, 1), 32'd3);
        wr_reg(tab(0, 4, 0), {14'h0, EN_YES, 16'd4900});
        wr_reg(tab(0, 4, 1), 32'd0);
        set_vt1 <= 16'd5200;
        wait_out(0, 0, 1'b1);
        wait_out(1, 0, 1'b1);
        chk("trip delay", partner.on_stamp[8] - partner.on_stamp[0], 32'd3);
        // just above pick-up the stage holds, 20 mHz below pick-up it releases
        set_vt1 <= 16'd5101;
        idle_ms(12);
        chk("hold", {31'h0, start[0]}, 32'h1);
        set_vt1 <= 16'd5098;
        wait_out(0, 0, 1'b0);
        chk("off stamp", partner.off_stamp[8], partner.off_stamp[0]);
        chk("off late", {31'h0, partner.off_stamp[0] > partner.on_stamp[8]}, 32'h1);
        rd_chk(`A_CNT_START, 32'h1);
        rd_chk(`A_CNT_TRIP, 32'h1);
        rd_chk(`A_CNT_BLK, 32'h0);
        // sticky status, mask and write-one-to-clear
        rd_chk(`A_IRQ_STAT, 32'h3);
        chk("irq", {31'h0, irq}, 32'h0);
        wr_reg(`A_IRQ_MASK, 32'h2);
        idle_ms(1);
        chk("irq", {31'h0, irq}, 32'h1);
        wr_reg(`A_IRQ_STAT, 32'h2);
        idle_ms(1);
        chk("irq", {31'h0, irq}, 32'h0);
        rd_chk(`A_IRQ_STAT, 32'h1);
        wr_reg(`A_IRQ_MASK, 32'h0);
        // instant under stage: start and trip share one stamp
        set_vt1 <= 16'd4800;
        wait_out(1, 4, 1'b1);
        chk("instant", partner.on_stamp[12], partner.on_stamp[4]);
        set_vt1 <= 16'd5000;
        wait_out(0, 4, 1'b0);
        // block present at pick-up gives blocked, never start
        block <= 1'b1;
        set_vt1 <= 16'd4800;
        wait_out(2, 4, 1'b1);
        chk("no start", {31'h0, start[4]}, 32'h0);
        set_vt1 <= 16'd5000;
        wait_out(2, 4, 1'b0);
        block <= 1'b0;
        // second transformer is ignored until tracking selects it
        set_vt2 <= 16'd5200;
        idle_ms(12);
        chk("track", {31'h0, start[0]}, 32'h0);
        wr_reg(`A_CTRL, 32'h501);
        wait_out(0, 0, 1'b1);
        // group 1 still has the stage disabled; mode is not grouped
        group_sel <= 3'h1;
        wait_out(0, 0, 1'b0);
        chk("node mode", 32'(node_mode), 32'(MODE_ON));
        set_vt2 <= 16'd5000;
        group_sel <= 3'h0;
        // forcing has no effect until globally enabled
        wr_reg(`A_FORCE, 32'h8);
        idle_ms(3);
        chk("force off", {31'h0, trip[1]}, 32'h0);
        wr_reg(`A_CTRL, 32'h301);
        for (int c = 0; c < 4; c++) begin
            wr_reg(`A_FORCE, 32'(c) << 2);
            idle_ms(3);
            chk("force start", {31'h0, start[1]}, 32'(c == 1 || c == 2));
            chk("force trip", {31'h0, trip[1]}, 32'(c == 2));
            chk("force blocked", {31'h0, blocked[1]}, 32'(c == 3));
        end
        give_verdict();
    end
endmodule
